// ---- por_consts.svh ----
// timing constants for the power-on reset generator
// assumes a 125 MHz free-running time base clock
`ifndef POR_CONSTS_SVH
`define POR_CONSTS_SVH

`define POR_CLK_MHZ        125
// hold after both rails good, in microseconds
`define POR_HOLD_US        1500
`define POR_HOLD_CYCLES    (`POR_HOLD_US * `POR_CLK_MHZ)
// pin low filter, in microseconds
`define POR_FILT_US        200
`define POR_FILT_CYCLES    (`POR_FILT_US * `POR_CLK_MHZ)
`define POR_CNT_W          20

`endif

// ---- por_pkg.sv ----
// types for the power-on reset generator
// assumes por_consts.svh is included by users of timing values
package por_pkg;

  typedef enum logic [1:0] {
    PowerHold,
    Running,
    PinHold
  } por_state_t;

  typedef struct packed {
    logic ioRailGood;
    logic coreRailGood;
  } rails_t;

  typedef struct packed {
    logic padOut;
    logic padOe;
  } pad_drive_t;

endpackage : por_pkg

// ---- power_on_reset_gen.sv ----
// power-on reset generator: rail-good and reset pin to internal core reset
// assumes inputs synchronous to clk, a free-running time base; pull-up external
`timescale 1ns/1ps
`include "por_consts.svh"

module power_on_reset_gen #(
  parameter int unsigned HOLD_CYCLES = `POR_HOLD_CYCLES,
  parameter int unsigned FILT_CYCLES = `POR_FILT_CYCLES
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // rail good indications
  input  wire por_pkg::rails_t rails,
  // open-drain reset pad
  input  wire logic           chipRstPadIn,
  output logic                chipRstPadOut,
  output logic                chipRstPadOe,
  // internal core reset
  output logic                coreRst_n
);

  // ***********************************************************
  // state
  // ***********************************************************
  por_pkg::por_state_t                 state_reg,   state_next;
  logic [`POR_CNT_W-1:0]               holdCnt_reg, holdCnt_next;
  logic [`POR_CNT_W-1:0]               filtCnt_reg, filtCnt_next;
  logic                                coreRst_n_reg, coreRst_n_next;
  logic                                padOe_reg,   padOe_next;
  logic                                railsOk;
  logic                                padLow;

  localparam logic [`POR_CNT_W-1:0] HOLD_LAST = `POR_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [`POR_CNT_W-1:0] FILT_LAST = `POR_CNT_W'(FILT_CYCLES - 1);
  // counter width is fixed: counts must stay below 2**POR_CNT_W or they wrap

  assign railsOk = rails.ioRailGood & rails.coreRailGood;
  // our own drive also pulls the pad low, so only sample when released
  assign padLow  = ~chipRstPadIn & ~padOe_reg;

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    state_next     = state_reg;
    holdCnt_next   = holdCnt_reg;
    filtCnt_next   = filtCnt_reg;
    coreRst_n_next = coreRst_n_reg;
    padOe_next     = padOe_reg;
    if (!railsOk) begin
      // any rail loss wins over everything else
      state_next     = por_pkg::PowerHold;
      holdCnt_next   = '0;
      filtCnt_next   = '0;
      coreRst_n_next = 1'b0;
      // released: pin follows the rail through the pull-up
      padOe_next     = 1'b0;
    end else begin
      unique case (state_reg)
        por_pkg::PowerHold: begin
          coreRst_n_next = 1'b0;
          padOe_next     = 1'b1;
          if (holdCnt_reg == HOLD_LAST) begin
            state_next     = por_pkg::Running;
            coreRst_n_next = 1'b1;
            padOe_next     = 1'b0;
            holdCnt_next   = '0;
          end else begin
            holdCnt_next = holdCnt_reg + `POR_CNT_W'(1);
          end
        end
        por_pkg::Running: begin
          padOe_next = 1'b0;
          if (padLow) begin
            if (filtCnt_reg == FILT_LAST) begin
              state_next     = por_pkg::PinHold;
              coreRst_n_next = 1'b0;
              filtCnt_next   = '0;
            end else begin
              filtCnt_next = filtCnt_reg + `POR_CNT_W'(1);
            end
          end else begin
            filtCnt_next = '0;
          end
        end
        por_pkg::PinHold: begin
          // reset stays on while pin low, released when pin rises
          coreRst_n_next = 1'b0;
          if (!padLow) begin
            state_next     = por_pkg::Running;
            coreRst_n_next = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= por_pkg::PowerHold;
      holdCnt_reg   <= '0;
      filtCnt_reg   <= '0;
      coreRst_n_reg <= 1'b0;
      padOe_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      holdCnt_reg   <= holdCnt_next;
      filtCnt_reg   <= filtCnt_next;
      coreRst_n_reg <= coreRst_n_next;
      padOe_reg     <= padOe_next;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // the pad never drives high
  assign chipRstPadOut = 1'b0;
  assign chipRstPadOe  = padOe_reg;
  assign coreRst_n     = coreRst_n_reg;

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_rail_loss;
    @(posedge clk) disable iff (!rst_n) !railsOk |=> !coreRst_n;
  endproperty
  a_rail_loss: assert property (p_rail_loss) else $error("reset not asserted on rail loss");

  property p_pad_low_only;
    @(posedge clk) disable iff (!rst_n) chipRstPadOut == 1'b0;
  endproperty
  a_pad_low_only: assert property (p_pad_low_only) else $error("pad driven high");

  property p_hold_min;
    @(posedge clk) disable iff (!rst_n)
      $rose(coreRst_n) && $past(state_reg) == por_pkg::PowerHold |-> holdCnt_reg == '0 && $past(holdCnt_reg) == HOLD_LAST;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset released before hold time");

  property p_rails_release;
    @(posedge clk) disable iff (!rst_n) $rose(coreRst_n) |-> $past(railsOk);
  endproperty
  a_rails_release: assert property (p_rails_release) else $error("reset released with rail low");

  property p_drive_in_hold;
    @(posedge clk) disable iff (!rst_n)
      state_reg == por_pkg::PowerHold && railsOk ##1 state_reg == por_pkg::PowerHold |-> chipRstPadOe;
  endproperty
  a_drive_in_hold: assert property (p_drive_in_hold) else $error("pad not driven during power hold");

  property p_release_both;
    @(posedge clk) disable iff (!rst_n)
      $past(state_reg) == por_pkg::PowerHold && state_reg == por_pkg::Running |-> coreRst_n && !chipRstPadOe;
  endproperty
  a_release_both: assert property (p_release_both) else $error("driver and reset not released together");

  property p_running_off;
    @(posedge clk) disable iff (!rst_n)
      state_reg == por_pkg::Running |-> !chipRstPadOe && coreRst_n;
  endproperty
  a_running_off: assert property (p_running_off) else $error("driver on in normal operation");

  // a one-cycle rail glitch also drops reset, so key on the rails at the drop edge
  property p_filter;
    @(posedge clk) disable iff (!rst_n)
      $fell(coreRst_n) && $past(railsOk) && $past(state_reg) == por_pkg::Running |-> $past(filtCnt_reg) == FILT_LAST;
  endproperty
  a_filter: assert property (p_filter) else $error("pin reset without full filter time");

  property p_cnt_restart;
    @(posedge clk) disable iff (!rst_n) !railsOk |=> holdCnt_reg == '0;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) else $error("hold counter not restarted");

  property p_pin_release;
    @(posedge clk) disable iff (!rst_n)
      state_reg == por_pkg::PinHold && chipRstPadIn && railsOk |=> coreRst_n;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("reset not released after pin rise");

  property p_drive_only_hold;
    @(posedge clk) disable iff (!rst_n) chipRstPadOe |-> state_reg == por_pkg::PowerHold && !coreRst_n;
  endproperty
  a_drive_only_hold: assert property (p_drive_only_hold) else $error("pad driven outside power hold");

  property p_filter_clear;
    @(posedge clk) disable iff (!rst_n)
      state_reg == por_pkg::Running && chipRstPadIn |=> filtCnt_reg == '0;
  endproperty
  a_filter_clear: assert property (p_filter_clear) else $error("filter not cleared by high pad");

  property p_pin_hold_low;
    @(posedge clk) disable iff (!rst_n) state_reg == por_pkg::PinHold |-> !coreRst_n && !chipRstPadOe;
  endproperty
  a_pin_hold_low: assert property (p_pin_hold_low) else $error("core reset released while pin held");

  property p_cnt_bound;
    @(posedge clk) disable iff (!rst_n) holdCnt_reg <= HOLD_LAST && filtCnt_reg <= FILT_LAST;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("reset counter beyond its last value");

  // main scenarios: power-up, pin reset, rail loss, short press

  c_power_up:  cover property (@(posedge clk) disable iff (!rst_n) $rose(coreRst_n));
  c_pin_reset: cover property (@(posedge clk) disable iff (!rst_n) state_reg == por_pkg::PinHold);
  c_glitch:    cover property (@(posedge clk) disable iff (!rst_n) state_reg == por_pkg::Running ##1 !railsOk);
  c_pin_drop:  cover property (@(posedge clk) disable iff (!rst_n) state_reg == por_pkg::PinHold ##1 !railsOk);
  c_short_press: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == por_pkg::Running && filtCnt_reg != '0 ##1 filtCnt_reg == '0 && state_reg == por_pkg::Running);

endmodule : power_on_reset_gen

// ---- pad_pull_model.sv ----
// pad model: external pull-up plus open-drain push-button
// assumes the device output enable is high while it pulls the pad low
`timescale 1ns/1ps
module pad_pull_model (
  // drivers of the pad
  input  wire logic devOe,
  input  wire logic press,
  // resolved pad level
  output logic      padLevel
);
  // button only sinks; released pad floats up through the pull-up
  assign padLevel = (devOe || press) ? 1'b0 : 1'b1;
endmodule : pad_pull_model

// ---- power_on_reset_gen_tb.sv ----
// testbench for power_on_reset_gen with shortened hold and filter counts
// assumes pad_pull_model resolves the open-drain pad level
`timescale 1ns/1ps
module power_on_reset_gen_tb;
  localparam int HOLD = 20;
  localparam int FILT = 5;
  logic            clk        = 1'b0;
  logic            rst_n      = 1'b0;
  por_pkg::rails_t rails      = 2'h0;
  logic            press      = 1'b0;
  logic            padLevel;
  logic            chipRstPadOut;
  logic            chipRstPadOe;
  logic            coreRst_n;
  int              bad_count  = 0;
  int              num_checks = 0;
  int              cycles     = 0;
  // press length, expected core reset at end of press
  int              rows[4][2] = '{'{1, 1}, '{FILT - 1, 1}, '{FILT, 0}, '{FILT + 3, 0}};

  power_on_reset_gen #(.HOLD_CYCLES(HOLD), .FILT_CYCLES(FILT)) power_on_reset_gen_i (
    .clk(clk), .rst_n(rst_n), .rails(rails), .chipRstPadIn(padLevel),
    .chipRstPadOut(chipRstPadOut), .chipRstPadOe(chipRstPadOe), .coreRst_n(coreRst_n));
  pad_pull_model pad_pull_model_i (.devOe(chipRstPadOe), .press(press), .padLevel(padLevel));

  always #4 clk = ~clk;

  // **********
  // helpers
  // **********
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task check(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0b seen %0b", name, exp, got);
    end
  endtask : check

  task wait_cyc(int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  // full hold after a cause; the next rising edge is the first good one
  task check_hold();
    wait_cyc(1);
    check("holdOe", 1'b1, chipRstPadOe);
    wait_cyc(HOLD - 2);
    check("holdMin", 1'b0, coreRst_n);
    wait_cyc(1);
    check("holdEnd", 1'b1, coreRst_n);
    check("holdOeOff", 1'b0, chipRstPadOe);
  endtask : check_hold

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  // **********
  // sequence
  // **********
  initial begin
    wait_cyc(8);
    rst_n = 1'b1;
    wait_cyc(1);
    rails = 2'h3;
    wait_cyc(2);
    check("oe", 1'b1, chipRstPadOe);
    check("padOut", 1'b0, chipRstPadOut);
    wait_cyc(HOLD - 3);
    check("holdLow", 1'b0, coreRst_n);
    wait_cyc(2);
    check("holdRel", 1'b1, coreRst_n);
    check("oeOff", 1'b0, chipRstPadOe);
    foreach (rows[r]) begin
      press = 1'b1;
      wait_cyc(rows[r][0]);
      check("filter", rows[r][1][0], coreRst_n);
      press = 1'b0;
      wait_cyc(2);
      check("pinRel", 1'b1, coreRst_n);
    end
    // io rail lost while running
    rails = 2'h1;
    wait_cyc(2);
    check("drop", 1'b0, coreRst_n);
    check("dropOe", 1'b0, chipRstPadOe);
    rails = 2'h3;
    wait_cyc(HOLD - 1);
    check("reHold", 1'b0, coreRst_n);
    wait_cyc(2);
    check("reRel", 1'b1, coreRst_n);
    // one-cycle glitch on the core rail
    rails = 2'h2;
    wait_cyc(1);
    check("glitch", 1'b0, coreRst_n);
    rails = 2'h3;
    check_hold();
    // rail loss while the pin holds reset; press kept through the hold
    press = 1'b1;
    wait_cyc(FILT + 1);
    check("pinHold", 1'b0, coreRst_n);
    rails = 2'h2;
    wait_cyc(1);
    check("pinDrop", 1'b0, coreRst_n);
    rails = 2'h3;
    check_hold();
    // press overlapping the hold is masked by our own drive
    press = 1'b0;
    wait_cyc(FILT);
    check("maskedPress", 1'b1, coreRst_n);
    // reset of the logic itself in mid-run
    rst_n = 1'b0;
    wait_cyc(2);
    check("rstCore", 1'b0, coreRst_n);
    check("rstOe", 1'b0, chipRstPadOe);
    rst_n = 1'b1;
    check_hold();
    complete_run();
  end
endmodule : power_on_reset_gen_tb
